//--- inc/bwc_regs.vh
`ifndef BWC_REGS_VH
`define BWC_REGS_VH
// ******************************************************
// register offsets (byte addresses)
// ******************************************************
`define BWC_OFF_PF_BASE_HI 8'h28
`define BWC_OFF_PF_LIMIT_HI 8'h2c
`define BWC_OFF_IO_HI 8'h30
`define BWC_OFF_CAP_PTR 8'h34
`define BWC_OFF_IRQ_CTRL 8'h3c
`define BWC_OFF_LOW_WIN 8'h50
`define BWC_OFF_IRQ_STAT 8'h54
`define BWC_OFF_IRQ_EN 8'h58
`define BWC_OFF_IRQ_CLR 8'h5c
// ******************************************************
// fields and reset values
// ******************************************************
`define BWC_BIT_PERR_RESP 16
`define BWC_BIT_SERR_FWD 17
`define BWC_BIT_LEGACY_IO 18
`define BWC_BIT_VGA 19
`define BWC_RST_CAP_PTR 8'h40
`define BWC_RST_IRQ_PIN 8'h00
`define BWC_VGA_MEM_LO 64'h00000000000a0000
`define BWC_VGA_MEM_HI 64'h00000000000bffff
`define BWC_IO_64K_TOP 32'h0000ffff
// status bit positions
`define BWC_ST_POISON 0
`define BWC_ST_ERRFWD 1
`define BWC_ST_IOUP 2
`endif

//--- rtl/bwc_range_cmp.v
`include "bwc_regs.vh"
// inclusive window test
module bwc_range_cmp #(
  parameter W = 64
) (
  // operands
  input wire [W-1:0] addr_i,
  input wire [W-1:0] base_i,
  input wire [W-1:0] limit_i,
  // result
  output wire hit_o
);
  assign hit_o = (addr_i >= base_i) && (addr_i <= limit_i);
endmodule

//--- rtl/bwc_bridge_cfg.v
// The AXI4-Lite register port was left to the implementer.
`include "bwc_regs.vh"
// Function
// - prefetch window base bits 63:32, writable, reset zero.
// - prefetch window limit bits 63:32, writable, reset zero.
// - io window base bits 31:16 in word bits 15:0, reset zero.
// - io window limit bits 31:16 in word bits 31:16, reset zero.
// - read-only capability pointer, reset 40h, locates power management.
// - read-only interrupt pin field bits 15:8, reset 00h.
// - interrupt pin default replaceable by serial loader on downstream ports.
// - bit 16 clear ignores poisoned secondary packets; set reports them.
// - bit 17 gates error messages from secondary to primary.
// - bit 18 clear forwards every in-range io address downstream.
// - bit 18 set sends upstream in-window io in the top 768 bytes per 1KB below 64KB, except vga io while bit 19 is set.
// - bit 19 enables forwarding of vga memory and io ranges.
// - vga memory is a0000h..bffffh; vga io decoded below 64KB only.
// - prefetch base assembled with bits 19:0 zero.
// - prefetch limit assembled with bits 19:0 all ones.
module bwc_bridge_cfg (
  // clock and reset
  input wire clk_i,
  input wire resetn_i,
  // axi4-lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // axi4-lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // axi4-lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // interrupt pin default loader (smbus or eeprom)
  input wire pin_load_i,
  input wire [7:0] pin_load_val_i,
  // memory transaction to classify
  input wire mem_req_i,
  input wire [63:0] mem_addr_i,
  // io transaction to classify
  input wire io_req_i,
  input wire [31:0] io_addr_i,
  // secondary side events
  input wire sec_poison_i,
  input wire sec_err_msg_i,
  // decisions
  output reg mem_fwd_o,
  output reg io_fwd_down_o,
  output reg io_fwd_up_o,
  output reg err_fwd_o,
  output reg poison_report_o,
  // control bits
  output reg perr_resp_o,
  output reg legacy_io_block_filter_o,
  output reg vga_enable_o,
  // interrupt
  output reg irq_o
);
  // ******************************************************
  // registers
  // ******************************************************
  reg [31:0] prefetch_window_base_high;
  reg [31:0] prefetch_window_limit_high;
  reg [15:0] io_window_base_high;
  reg [15:0] io_window_limit_high;
  reg [7:0] irq_routing_line;
  reg [7:0] irq_pin_select;
  reg secondary_error_forward_enable;
  // lower window bits normally live elsewhere in the header
  reg [11:0] pf_base_low;
  reg [11:0] pf_limit_low;
  reg [3:0] io_base_low;
  reg [3:0] io_limit_low;
  reg [2:0] irq_status;
  reg [2:0] irq_enable;
  // ******************************************************
  // bus slave
  // ******************************************************
  reg [7:0] wr_addr;
  reg [31:0] wr_data;
  reg [3:0] wr_strb;
  reg have_aw;
  reg have_w;
  reg [2:0] clr_pulse;
  wire do_write;
  wire [31:0] bmask;
  wire wr_ok;
  assign do_write = have_aw && have_w && !s_axi_bvalid;
  assign bmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
                  {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wr_ok = (wr_addr == `BWC_OFF_PF_BASE_HI) ||
                 (wr_addr == `BWC_OFF_PF_LIMIT_HI) ||
                 (wr_addr == `BWC_OFF_IO_HI) ||
                 (wr_addr == `BWC_OFF_CAP_PTR) ||
                 (wr_addr == `BWC_OFF_IRQ_CTRL) ||
                 (wr_addr == `BWC_OFF_LOW_WIN) ||
                 (wr_addr == `BWC_OFF_IRQ_STAT) ||
                 (wr_addr == `BWC_OFF_IRQ_EN) ||
                 (wr_addr == `BWC_OFF_IRQ_CLR);

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      have_aw <= 1'b0;
      have_w <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      // ready is offered one cycle, so each channel is taken singly
      s_axi_awready <= !have_aw && s_axi_awvalid && !s_axi_awready;
      s_axi_wready <= !have_w && s_axi_wvalid && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        have_aw <= 1'b1;
        wr_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        have_w <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'h0 : 2'h3;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ******************************************************
  // register writes
  // ******************************************************
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      prefetch_window_base_high <= 32'h00000000;
      prefetch_window_limit_high <= 32'h00000000;
      io_window_base_high <= 16'h0000;
      io_window_limit_high <= 16'h0000;
      irq_routing_line <= 8'h00;
      perr_resp_o <= 1'b0;
      secondary_error_forward_enable <= 1'b0;
      legacy_io_block_filter_o <= 1'b0;
      vga_enable_o <= 1'b0;
      pf_base_low <= 12'h000;
      pf_limit_low <= 12'h000;
      io_base_low <= 4'h0;
      io_limit_low <= 4'h0;
      irq_enable <= 3'h0;
      clr_pulse <= 3'h0;
    end else begin
      clr_pulse <= 3'h0;
      if (do_write) begin
        if (wr_addr == `BWC_OFF_PF_BASE_HI) begin
          prefetch_window_base_high <= (wr_data & bmask) |
            (prefetch_window_base_high & ~bmask);
        end else if (wr_addr == `BWC_OFF_PF_LIMIT_HI) begin
          prefetch_window_limit_high <= (wr_data & bmask) |
            (prefetch_window_limit_high & ~bmask);
        end else if (wr_addr == `BWC_OFF_IO_HI) begin
          if (wr_strb[0]) io_window_base_high[7:0] <= wr_data[7:0];
          if (wr_strb[1]) io_window_base_high[15:8] <= wr_data[15:8];
          if (wr_strb[2]) io_window_limit_high[7:0] <= wr_data[23:16];
          if (wr_strb[3]) io_window_limit_high[15:8] <= wr_data[31:24];
        end else if (wr_addr == `BWC_OFF_IRQ_CTRL) begin
          if (wr_strb[0]) irq_routing_line <= wr_data[7:0];
          // pin byte is read-only; bits 20 and up are not held here
          if (wr_strb[2]) begin
            perr_resp_o <= wr_data[`BWC_BIT_PERR_RESP];
            secondary_error_forward_enable <=
              wr_data[`BWC_BIT_SERR_FWD];
            legacy_io_block_filter_o <= wr_data[`BWC_BIT_LEGACY_IO];
            vga_enable_o <= wr_data[`BWC_BIT_VGA];
          end
        end else if (wr_addr == `BWC_OFF_LOW_WIN) begin
          if (wr_strb[0]) io_base_low <= wr_data[3:0];
          if (wr_strb[0]) io_limit_low <= wr_data[7:4];
          if (wr_strb[1]) pf_base_low[3:0] <= wr_data[11:8];
          if (wr_strb[2]) pf_base_low[11:4] <= wr_data[23:16];
          if (wr_strb[1]) pf_limit_low[3:0] <= wr_data[15:12];
          if (wr_strb[3]) pf_limit_low[11:4] <= wr_data[31:24];
        end else if (wr_addr == `BWC_OFF_IRQ_EN) begin
          if (wr_strb[0]) irq_enable <= wr_data[2:0];
        end else if (wr_addr == `BWC_OFF_IRQ_CLR) begin
          if (wr_strb[0]) clr_pulse <= wr_data[2:0];
        end
      end
    end
  end

  // ******************************************************
  // interrupt pin default load
  // ******************************************************
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      irq_pin_select <= `BWC_RST_IRQ_PIN;
    end else if (pin_load_i) begin
      irq_pin_select <= pin_load_val_i;
    end
  end

  // ******************************************************
  // read channel
  // ******************************************************
  reg [31:0] rd_word;
  reg rd_ok;
  wire [7:0] ra;
  assign ra = {s_axi_araddr[7:2], 2'b00};
  always @* begin
    rd_word = 32'h00000000;
    rd_ok = 1'b1;
    if (ra == `BWC_OFF_PF_BASE_HI) begin
      rd_word = prefetch_window_base_high;
    end else if (ra == `BWC_OFF_PF_LIMIT_HI) begin
      rd_word = prefetch_window_limit_high;
    end else if (ra == `BWC_OFF_IO_HI) begin
      rd_word = {io_window_limit_high, io_window_base_high};
    end else if (ra == `BWC_OFF_CAP_PTR) begin
      rd_word = {24'h000000, `BWC_RST_CAP_PTR};
    end else if (ra == `BWC_OFF_IRQ_CTRL) begin
      rd_word = {12'h000, vga_enable_o, legacy_io_block_filter_o,
                 secondary_error_forward_enable, perr_resp_o,
                 irq_pin_select, irq_routing_line};
    end else if (ra == `BWC_OFF_LOW_WIN) begin
      rd_word = {pf_limit_low[11:4], pf_base_low[11:4],
                 pf_limit_low[3:0], pf_base_low[3:0],
                 io_limit_low, io_base_low};
    end else if (ra == `BWC_OFF_IRQ_STAT) begin
      rd_word = {29'h00000000, irq_status};
    end else if (ra == `BWC_OFF_IRQ_EN) begin
      rd_word = {29'h00000000, irq_enable};
    end else if (ra == `BWC_OFF_IRQ_CLR) begin
      rd_word = 32'h00000000;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_ok ? 2'h0 : 2'h3;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ******************************************************
  // forwarding decisions
  // ******************************************************
  wire [63:0] pf_base;
  wire [63:0] pf_limit;
  wire [31:0] io_base;
  wire [31:0] io_limit;
  wire pf_hit;
  wire vga_mem_hit;
  wire io_hit;
  wire io_low64k;
  wire io_legacy_alias;
  wire vga_io_hit;
  assign pf_base = {prefetch_window_base_high, pf_base_low, 20'h00000};
  assign pf_limit = {prefetch_window_limit_high, pf_limit_low,
                     20'hfffff};
  // io granule is 4KB, as in the classic bridge header
  assign io_base = {io_window_base_high, io_base_low, 12'h000};
  assign io_limit = {io_window_limit_high, io_limit_low, 12'hfff};

  bwc_range_cmp #(.W(64)) u_pf_cmp (
    .addr_i(mem_addr_i),
    .base_i(pf_base),
    .limit_i(pf_limit),
    .hit_o(pf_hit)
  );
  bwc_range_cmp #(.W(64)) u_vga_cmp (
    .addr_i(mem_addr_i),
    .base_i(`BWC_VGA_MEM_LO),
    .limit_i(`BWC_VGA_MEM_HI),
    .hit_o(vga_mem_hit)
  );
  bwc_range_cmp #(.W(32)) u_io_cmp (
    .addr_i(io_addr_i),
    .base_i(io_base),
    .limit_i(io_limit),
    .hit_o(io_hit)
  );

  assign io_low64k = io_addr_i <= `BWC_IO_64K_TOP;
  // top 768 bytes of each 1KB block: offset bits 9:8 not both zero
  assign io_legacy_alias = io_low64k && (io_addr_i[9:8] != 2'b00);
  // vga io: 3b0-3bb and 3c0-3df, 10-bit decode
  assign vga_io_hit = io_low64k &&
    (((io_addr_i[9:0] >= 10'h3b0) && (io_addr_i[9:0] <= 10'h3bb)) ||
     ((io_addr_i[9:0] >= 10'h3c0) && (io_addr_i[9:0] <= 10'h3df)));

  always @(posedge clk_i) begin
    if (!resetn_i) begin
      mem_fwd_o <= 1'b0;
      io_fwd_down_o <= 1'b0;
      io_fwd_up_o <= 1'b0;
      err_fwd_o <= 1'b0;
      poison_report_o <= 1'b0;
    end else begin
      mem_fwd_o <= mem_req_i &&
        (pf_hit || (vga_enable_o && vga_mem_hit));
      if (legacy_io_block_filter_o && io_hit && io_legacy_alias) begin
        io_fwd_down_o <= io_req_i && vga_enable_o && vga_io_hit;
        io_fwd_up_o <= io_req_i && !(vga_enable_o && vga_io_hit);
      end else begin
        io_fwd_down_o <= io_req_i &&
          (io_hit || (vga_enable_o && vga_io_hit));
        io_fwd_up_o <= 1'b0;
      end
      err_fwd_o <= sec_err_msg_i && secondary_error_forward_enable;
      poison_report_o <= sec_poison_i && perr_resp_o;
    end
  end

  // ******************************************************
  // interrupt status; set wins over clear
  // ******************************************************
  wire [2:0] ev;
  assign ev = {io_fwd_up_o, err_fwd_o, poison_report_o};
  always @(posedge clk_i) begin
    if (!resetn_i) begin
      irq_status <= 3'h0;
      irq_o <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~clr_pulse) | ev;
      irq_o <= |(((irq_status & ~clr_pulse) | ev) & irq_enable);
    end
  end
endmodule

//--- bench/bwc_cfg_properties.sv
`include "bwc_regs.vh"
module bwc_cfg_props (
  // clock and reset
  input wire clk_i,
  input wire resetn_i,
  // bus answers
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // requests and events
  input wire mem_req_i,
  input wire [63:0] mem_addr_i,
  input wire io_req_i,
  input wire [31:0] io_addr_i,
  input wire sec_poison_i,
  input wire sec_err_msg_i,
  // decisions
  input wire mem_fwd_o,
  input wire io_fwd_down_o,
  input wire io_fwd_up_o,
  input wire err_fwd_o,
  input wire poison_report_o,
  input wire perr_resp_o,
  input wire vga_enable_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  bvalid_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
  ) else $error("write answer dropped early");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
  ) else $error("read answer changed while waiting");
  err_source_a: assert property (
    err_fwd_o |-> $past(sec_err_msg_i)
  ) else $error("error forwarded without message");
  poison_source_a: assert property (
    poison_report_o |-> $past(sec_poison_i)
  ) else $error("poison reported without packet");
  poison_ignored_a: assert property (
    $past(sec_poison_i) && !$past(perr_resp_o) && !perr_resp_o
      |-> !poison_report_o
  ) else $error("poison reported while response off");
  io_exclusive_a: assert property (
    !(io_fwd_up_o && io_fwd_down_o)
  ) else $error("io sent both ways");
  io_up_range_a: assert property (
    io_fwd_up_o |-> $past(io_req_i) && $past(io_addr_i) <= `BWC_IO_64K_TOP
      && ($past(io_addr_i) & 32'h00000300) != 32'h00000000
  ) else $error("io sent upstream outside legacy blocks");
  vga_mem_fwd_a: assert property (
    $past(mem_req_i) && $past(vga_enable_o) && vga_enable_o
      && $past(mem_addr_i) >= `BWC_VGA_MEM_LO
      && $past(mem_addr_i) <= `BWC_VGA_MEM_HI |-> mem_fwd_o
  ) else $error("vga memory not forwarded");
  mem_idle_a: assert property (
    !$past(mem_req_i) |-> !mem_fwd_o
  ) else $error("memory forward without request");
  io_idle_a: assert property (
    !$past(io_req_i) |-> !io_fwd_down_o && !io_fwd_up_o
  ) else $error("io decision without request");
endmodule
bind bwc_bridge_cfg bwc_cfg_props bwc_cfg_props_inst (
  .clk_i(clk_i), .resetn_i(resetn_i), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .mem_req_i(mem_req_i), .mem_addr_i(mem_addr_i), .io_req_i(io_req_i),
  .io_addr_i(io_addr_i), .sec_poison_i(sec_poison_i),
  .sec_err_msg_i(sec_err_msg_i), .mem_fwd_o(mem_fwd_o),
  .io_fwd_down_o(io_fwd_down_o), .io_fwd_up_o(io_fwd_up_o),
  .err_fwd_o(err_fwd_o), .poison_report_o(poison_report_o),
  .perr_resp_o(perr_resp_o), .vga_enable_o(vga_enable_o)
);

//--- bench/bwc_far_side.sv
module bwc_far_side (
  // clock
  input wire clk_i,
  // requests toward the bridge
  output logic mem_req_o = 1'h0,
  output logic [63:0] mem_addr_o = 64'h0,
  output logic io_req_o = 1'h0,
  output logic [31:0] io_addr_o = 32'h0,
  // secondary side events
  output logic sec_poison_o = 1'h0,
  output logic sec_err_msg_o = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // released address lines show the inverse so stale values never match
  task automatic mem_probe(input logic [63:0] a);
    mem_req_o <= 1'h1;
    mem_addr_o <= a;
    @(posedge clk_i);
    mem_req_o <= 1'h0;
    mem_addr_o <= ~a;
  endtask
  task automatic io_probe(input logic [31:0] a);
    io_req_o <= 1'h1;
    io_addr_o <= a;
    @(posedge clk_i);
    io_req_o <= 1'h0;
    io_addr_o <= ~a;
  endtask
  task automatic sec_event(input logic p, input logic e);
    sec_poison_o <= p;
    sec_err_msg_o <= e;
    @(posedge clk_i);
    sec_poison_o <= 1'h0;
    sec_err_msg_o <= 1'h0;
  endtask
endmodule

//--- bench/test_bridge_window_and_control_cfg.sv
`include "bwc_regs.vh"
module test_bridge_window_and_control_cfg;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'h0, resetn_i = 1'h0, pin_load_i = 1'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0, pin_val = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic mem_req, io_req, poison, err_msg;
  logic [63:0] mem_addr;
  logic [31:0] io_addr;
  logic mem_fwd, io_down, io_up, err_fwd, poison_rep, perr, legacy, vga, irq;
  int bad_count = 0, total_checks = 0, cycles = 0;
  logic [6:0] mhit;
  logic [63:0] ma [7] = '{64'h110000000, 64'h10fffffff, 64'h210ffffff,
    64'h211000000, 64'ha0000, 64'hbffff, 64'hc0000};
  logic [31:0] ia [12] = '{32'h1000, 32'hfff, 32'h12fff, 32'h13000,
    32'h1100, 32'h1000, 32'h10100, 32'h100, 32'h13c0, 32'h13c0,
    32'h3c0, 32'h133c0};
  logic [3:0] ic [12] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h4, 4'h4, 4'h4, 4'h4,
    4'h4, 4'hc, 4'h8, 4'h8};
  logic [1:0] ie [12] = '{2'h2, 2'h0, 2'h2, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0,
    2'h1, 2'h2, 2'h2, 2'h0};
  bwc_bridge_cfg bwc_bridge_cfg_inst (.clk_i(clk_i), .resetn_i(resetn_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_load_i(pin_load_i),
    .pin_load_val_i(pin_val), .mem_req_i(mem_req), .mem_addr_i(mem_addr),
    .io_req_i(io_req), .io_addr_i(io_addr), .sec_poison_i(poison),
    .sec_err_msg_i(err_msg), .mem_fwd_o(mem_fwd), .io_fwd_down_o(io_down),
    .io_fwd_up_o(io_up), .err_fwd_o(err_fwd), .poison_report_o(poison_rep),
    .perr_resp_o(perr), .legacy_io_block_filter_o(legacy),
    .vga_enable_o(vga), .irq_o(irq));
  bwc_far_side bwc_far_side_inst (.clk_i(clk_i), .mem_req_o(mem_req),
    .mem_addr_o(mem_addr), .io_req_o(io_req), .io_addr_o(io_addr),
    .sec_poison_o(poison), .sec_err_msg_o(err_msg));
  // ****************
  // tasks
  // ****************
  always #50 clk_i = ~clk_i;
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      end_sim();
    end
  end
  task automatic check(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  // both channels offered together, each dropped at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    // no cycle limit here: only the bench timeout ends a hung wait
    do begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    check("bresp", 32'(er), 32'(bresp));
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    check("rdata", e, rdata);
    check("rresp", 32'h0, 32'(rresp));
    @(posedge clk_i);
  endtask
  task automatic ctl(input logic [3:0] c);
    wr(`BWC_OFF_IRQ_CTRL, {12'h0, c, 16'h0}, 4'hf, 2'h0);
  endtask
  task automatic ev(input logic p, e, ep, ee, ei);
    bwc_far_side_inst.sec_event(p, e);
    #1;
    check("poison_err", {ep, ee}, {poison_rep, err_fwd});
    @(posedge clk_i);
    #1;
    check("irq", ei, irq);
    @(posedge clk_i);
  endtask
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'h1;
    @(posedge clk_i);
    rd(`BWC_OFF_PF_BASE_HI, 32'h0);
    rd(`BWC_OFF_PF_LIMIT_HI, 32'h0);
    rd(`BWC_OFF_IO_HI, 32'h0);
    rd(`BWC_OFF_CAP_PTR, 32'h40);
    rd(`BWC_OFF_IRQ_CTRL, 32'h0);
    wr(8'h80, 32'h1, 4'hf, 2'h3);
    wr(`BWC_OFF_PF_BASE_HI, 32'hffffffff, 4'h2, 2'h0);
    rd(`BWC_OFF_PF_BASE_HI, 32'h0000ff00);
    wr(`BWC_OFF_PF_BASE_HI, 32'h1, 4'hf, 2'h0);
    wr(`BWC_OFF_PF_LIMIT_HI, 32'h2, 4'hf, 2'h0);
    wr(`BWC_OFF_IO_HI, 32'h00010000, 4'hf, 2'h0);
    wr(`BWC_OFF_LOW_WIN, 32'h1010f021, 4'hf, 2'h0);
    wr(`BWC_OFF_CAP_PTR, 32'hff, 4'hf, 2'h0);
    wr(`BWC_OFF_IRQ_CTRL, 32'hffffffff, 4'hf, 2'h0);
    rd(`BWC_OFF_PF_BASE_HI, 32'h1);
    rd(`BWC_OFF_PF_LIMIT_HI, 32'h2);
    rd(`BWC_OFF_IO_HI, 32'h00010000);
    rd(`BWC_OFF_CAP_PTR, 32'h40);
    rd(`BWC_OFF_IRQ_CTRL, 32'h000f00ff);
    check("ctl_out", 32'h7, {perr, legacy, vga});
    pin_val <= 8'h01;
    pin_load_i <= 1'h1;
    @(posedge clk_i);
    pin_load_i <= 1'h0;
    rd(`BWC_OFF_IRQ_CTRL, 32'h000f01ff);
    // prefetch window 1_1000_0000..2_10ff_ffff, vga on then off
    for (int v = 1; v >= 0; v--) begin
      ctl(v ? 4'h8 : 4'h0);
      // one expected hit bit per probe address
      mhit = v ? 7'h35 : 7'h05;
      for (int i = 0; i < 7; i++) begin
        bwc_far_side_inst.mem_probe(ma[i]);
        #1;
        check("mem_fwd", mhit[i], mem_fwd);
        @(posedge clk_i);
      end
    end
    // io window 1000..1_2fff
    for (int i = 0; i < 12; i++) begin
      ctl(ic[i]);
      bwc_far_side_inst.io_probe(ia[i]);
      #1;
      check("io_down_up", ie[i], {io_down, io_up});
      @(posedge clk_i);
    end
    wr(`BWC_OFF_IRQ_CLR, 32'h7, 4'hf, 2'h0);
    wr(`BWC_OFF_IRQ_EN, 32'h7, 4'hf, 2'h0);
    ctl(4'h0);
    ev(1'h1, 1'h1, 1'h0, 1'h0, 1'h0);
    ctl(4'h3);
    ev(1'h1, 1'h1, 1'h1, 1'h1, 1'h1);
    rd(`BWC_OFF_IRQ_STAT, 32'h3);
    wr(`BWC_OFF_IRQ_CLR, 32'h1, 4'hf, 2'h0);
    rd(`BWC_OFF_IRQ_STAT, 32'h2);
    check("irq", 32'h1, irq);
    wr(`BWC_OFF_IRQ_CLR, 32'h2, 4'hf, 2'h0);
    check("irq", 32'h0, irq);
    wr(`BWC_OFF_IRQ_EN, 32'h0, 4'hf, 2'h0);
    ev(1'h1, 1'h0, 1'h1, 1'h0, 1'h0);
    rd(`BWC_OFF_IRQ_STAT, 32'h1);
    // mid-run reset must bring irq and the prefetch, io and irq control registers back to their reset values
    resetn_i <= 1'h0;
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'h1;
    @(posedge clk_i);
    check("irq", 32'h0, irq);
    rd(`BWC_OFF_PF_BASE_HI, 32'h0);
    rd(`BWC_OFF_PF_LIMIT_HI, 32'h0);
    rd(`BWC_OFF_IO_HI, 32'h0);
    rd(`BWC_OFF_IRQ_CTRL, 32'h0);
    end_sim();
  end
endmodule
